// >>> logic/nv_access_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH

`define MAC_ADDR        12'h0fa6
`define IRQ_STATUS_ADDR 12'h0fa8
`define IRQ_MASK_ADDR   12'h0fa9
`define NV_DATA_ADDR    12'h0faa
`define NV_ADDRL_ADDR   12'h0fab

`define MAC_MEM_SEL_BIT   7
`define MAC_CFG_SEL_BIT   6
`define MAC_ERASE_EN_BIT  4
`define MAC_WERR_BIT      3
`define MAC_WEN_BIT       2
`define MAC_WSTART_BIT    1
`define MAC_RSTART_BIT    0

`define IRQ_WDONE_BIT     0
`define IRQ_WERR_BIT      1
`define IRQ_USED_MASK     8'h03

`define BYTE_ZERO         8'h00
`define COUNT_ZERO        16'h0000
`define COUNT_ONE         16'h0001

// Self-timed write time in microseconds, and its count at 10 MHz.
`define WRITE_TIME_US     200
`define CLK_MHZ           10
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_MHZ)

`endif

// >>> logic/nv_access_pkg.sv
// Types shared by the non-volatile access control block.
`default_nettype none
package nv_access_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_ERASE = 3'b100
    } op_state_t;
endpackage
`default_nettype wire

// >>> logic/nv_memory_access_control.sv
// Control register, operation sequencer and event flags for non-volatile access.
//
// Chosen here: the address-and-strobe port.
`include "nv_access_regs.svh"
`default_nettype none

// ****************************************************************
// Overview
// ****************************************************************
// Software reaches five byte registers over a plain port: the access
// control register, an interrupt status and mask pair, the data byte
// and the byte address. Read data stand in the cycle after the read
// strobe and read as zero in every other cycle.
// A write start runs a self-timed program or row erase that lasts
// WRITE_CYCLES clocks; a read start loads the addressed data byte so
// that it can be read back from the second cycle after the start write.
// A warm reset request, from the master clear pin or the watchdog
// timer, passes two flops and then aborts any running operation.
// The interrupt status bits are sticky and cleared by writing ones.

// What this block does
// - Config select bit 6 routes access to configuration registers, else memory.
// - With erase enable set and program flash selected, next write start erases the pointed row.
// - Erase enable clears itself when its triggered erase completes.
// - With erase enable clear, write start only programs.
// - Write error flag records a write cut short; software reads it.
// - Master clear or watchdog reset during a write sets the error flag.
// - Read and write start bits are set-only; hardware clears them on completion.
// - Write start is refused unless the write gate was already set.
// - Data EEPROM read byte is ready in the second cycle after the read start write.
module nv_memory_access_control #(
    parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        warm_reset_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic             irq_o,
    output logic             target_flash_o,
    output logic             target_eeprom_o,
    output logic             target_config_o,
    output logic             nv_write_o,
    output logic             nv_erase_o,
    output logic             nv_read_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic                      mem_sel, next_mem_sel;
    logic                      cfg_sel, next_cfg_sel;
    logic                      erase_en, next_erase_en;
    logic                      werr, next_werr;
    logic                      wen, next_wen;
    logic                      wstart, next_wstart;
    logic                      rstart, next_rstart;
    nv_access_pkg::op_state_t  state, next_state;
    logic [15:0]               count, next_count;
    logic [7:0]                irq_status, next_irq_status;
    logic [7:0]                irq_mask, next_irq_mask;
    logic [7:0]                nv_data_byte, next_nv_data_byte;
    logic [7:0]                nv_byte_address, next_nv_byte_address;
    logic [7:0]                eeprom_mem [0:255];
    logic [7:0]                rdata, next_rdata;
    logic                      warm_meta, warm_sync, warm_prev;
    logic                      warm_edge;
    logic                      mac_wr;
    logic                      op_done;
    logic                      busy;

    // Decodes a control write and tracks whether an operation runs.
    assign mac_wr  = wr_i && (addr_i == `MAC_ADDR);
    assign busy    = (state != nv_access_pkg::ST_IDLE);
    assign op_done = busy && (count == `COUNT_ONE);
    // Warm reset edge: master clear or watchdog pulse, seen after sync.
    assign warm_edge = warm_sync && !warm_prev;

    // Two-flop synchroniser for the external warm reset request.
    // The request is asynchronous to this clock, so only the second
    // flop is read by logic; the first one only feeds the second.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            warm_meta <= 1'b0;
            warm_sync <= 1'b0;
            warm_prev <= 1'b0;
        end else begin
            warm_meta <= warm_reset_i;
            warm_sync <= warm_meta;
            warm_prev <= warm_sync;
        end
    end

    // ****************************************************************
    // Control register and sequencer next values
    // ****************************************************************
    // Next values of the control bits, the sequencer state and counter.
    always_comb begin
        next_mem_sel  = mem_sel;
        next_cfg_sel  = cfg_sel;
        next_erase_en = erase_en;
        next_werr     = werr;
        next_wen      = wen;
        next_wstart   = wstart;
        next_rstart   = 1'b0;                  // Read finishes in one cycle.
        next_state    = state;
        next_count    = count;
        if (mac_wr) begin
            next_wen     = wdata_i[`MAC_WEN_BIT];
            next_werr    = wdata_i[`MAC_WERR_BIT];
            // Selects are frozen while an operation runs, so a running
            // program or erase cannot be steered into another space.
            if (!busy) begin
                next_cfg_sel  = wdata_i[`MAC_CFG_SEL_BIT];
                next_mem_sel  = wdata_i[`MAC_MEM_SEL_BIT];
                next_erase_en = wdata_i[`MAC_ERASE_EN_BIT];
            end
            // Write start only when the gate was set before this write.
            if (wdata_i[`MAC_WSTART_BIT] && wen && !busy) begin
                next_wstart = 1'b1;
                next_count  = WRITE_CYCLES[15:0];
                // A row erase only exists in program flash space.
                if (erase_en && mem_sel && !cfg_sel) begin
                    next_state = nv_access_pkg::ST_ERASE;
                end else begin
                    next_state = nv_access_pkg::ST_WRITE;
                end
            end
            // Reads are taken only for data EEPROM space.
            if (wdata_i[`MAC_RSTART_BIT] && !wdata_i[`MAC_MEM_SEL_BIT]
                    && !wdata_i[`MAC_CFG_SEL_BIT] && !busy) begin
                next_rstart = 1'b1;
            end
        end
        // The counter runs down once a cycle; its last count ends the run.
        if (busy) begin
            next_count = count - `COUNT_ONE;
            if (!wen) begin
                // Gate dropped: the cycle is inhibited and counted as cut.
                next_state  = nv_access_pkg::ST_IDLE;
                next_wstart = 1'b0;
                next_count  = `COUNT_ZERO;
                next_werr   = 1'b1;
            end else if (op_done) begin
                next_state  = nv_access_pkg::ST_IDLE;
                next_wstart = 1'b0;
                if (state == nv_access_pkg::ST_ERASE) begin
                    next_erase_en = 1'b0;
                end
            end
        end
        // A warm reset overrides the gate, start bits, state and counter set above, so it comes last.
        if (warm_edge) begin
            // Reset of the core: clear control, keep selects and erase.
            next_wen    = 1'b0;
            next_wstart = 1'b0;
            next_rstart = 1'b0;
            next_state  = nv_access_pkg::ST_IDLE;
            next_count  = `COUNT_ZERO;
            if (busy) begin
                next_werr = 1'b1;
            end
        end
    end

    // Registers the control bits, the sequencer state and its counter.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_sel  <= 1'b0;
            cfg_sel  <= 1'b0;
            erase_en <= 1'b0;
            werr     <= 1'b0;
            wen      <= 1'b0;
            wstart   <= 1'b0;
            rstart   <= 1'b0;
            state    <= nv_access_pkg::ST_IDLE;
            count    <= `COUNT_ZERO;
        end else begin
            mem_sel  <= next_mem_sel;
            cfg_sel  <= next_cfg_sel;
            erase_en <= next_erase_en;
            werr     <= next_werr;
            wen      <= next_wen;
            wstart   <= next_wstart;
            rstart   <= next_rstart;
            state    <= next_state;
            count    <= next_count;
        end
    end

    // ****************************************************************
    // Data, address, interrupt and read-back next values
    // ****************************************************************
    // Next values of the data, address, interrupt and read-back state.
    always_comb begin
        next_irq_status      = irq_status;
        next_irq_mask        = irq_mask;
        next_nv_data_byte    = nv_data_byte;
        next_nv_byte_address = nv_byte_address;
        next_rdata           = `BYTE_ZERO;
        if (wr_i && addr_i == `IRQ_STATUS_ADDR) begin
            next_irq_status = irq_status & ~wdata_i;
        end
        if (wr_i && addr_i == `IRQ_MASK_ADDR) begin
            next_irq_mask = wdata_i & `IRQ_USED_MASK;
        end
        // Data and address are frozen while a write runs.
        if (wr_i && addr_i == `NV_DATA_ADDR && !busy) begin
            next_nv_data_byte = wdata_i;
        end
        if (wr_i && addr_i == `NV_ADDRL_ADDR && !busy) begin
            next_nv_byte_address = wdata_i;
        end
        // A read start loads the addressed byte on the edge after rstart is set,
        // so the data register holds it from the second cycle after the start write.
        if (rstart) begin
            next_nv_data_byte = eeprom_mem[nv_byte_address];
        end
        // Events set after clears so a set in the same cycle wins.
        if (op_done && wen && !warm_edge) begin
            next_irq_status[`IRQ_WDONE_BIT] = 1'b1;
        end
        if (busy && (!wen || warm_edge)) begin
            next_irq_status[`IRQ_WERR_BIT] = 1'b1;
        end
        // A warm reset zeroes data and address; software must reload both
        // before it retries a write that was cut short.
        if (warm_edge) begin
            next_nv_data_byte    = `BYTE_ZERO;
            next_nv_byte_address = `BYTE_ZERO;
        end
        // Read-back multiplexer; unmapped addresses read as zero.
        if (rd_i) begin
            case (addr_i)
                `MAC_ADDR: begin
                    next_rdata = {mem_sel, cfg_sel, 1'b0, erase_en,
                                  werr, wen, wstart, rstart};
                end
                `IRQ_STATUS_ADDR: next_rdata = irq_status;
                `IRQ_MASK_ADDR:   next_rdata = irq_mask;
                `NV_DATA_ADDR:    next_rdata = nv_data_byte;
                `NV_ADDRL_ADDR:   next_rdata = nv_byte_address;
                default:          next_rdata = `BYTE_ZERO;
            endcase
        end
    end

    // Registers the data, address, interrupt and read-back state.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_status      <= `BYTE_ZERO;
            irq_mask        <= `BYTE_ZERO;
            nv_data_byte    <= `BYTE_ZERO;
            nv_byte_address <= `BYTE_ZERO;
            rdata           <= `BYTE_ZERO;
        end else begin
            irq_status      <= next_irq_status;
            irq_mask        <= next_irq_mask;
            nv_data_byte    <= next_nv_data_byte;
            nv_byte_address <= next_nv_byte_address;
            rdata           <= next_rdata;
        end
    end

    // Data EEPROM array; a plain write programs the addressed byte.
    // The array has no reset: its contents survive every reset, as
    // non-volatile storage would.
    always_ff @(posedge clk_i) begin
        if (op_done && wen && !warm_edge && !mem_sel && !cfg_sel) begin
            eeprom_mem[nv_byte_address] <= nv_data_byte;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Every output comes from a flop fed with the next values, so the
    // outputs change on the same edge as the state that they mirror.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o         <= `BYTE_ZERO;
            irq_o           <= 1'b0;
            target_flash_o  <= 1'b0;
            target_eeprom_o <= 1'b0;
            target_config_o <= 1'b0;
            nv_write_o      <= 1'b0;
            nv_erase_o      <= 1'b0;
            nv_read_o       <= 1'b0;
        end else begin
            rdata_o         <= next_rdata;
            irq_o           <= |(next_irq_status & next_irq_mask);
            target_config_o <= next_cfg_sel;
            target_flash_o  <= !next_cfg_sel && next_mem_sel;
            target_eeprom_o <= !next_cfg_sel && !next_mem_sel;
            nv_write_o  <= (next_state == nv_access_pkg::ST_WRITE);
            nv_erase_o  <= (next_state == nv_access_pkg::ST_ERASE);
            nv_read_o   <= next_rstart;
        end
    end

endmodule
`default_nettype wire

// >>> sim/nv_access_monitor.sv
// Assertion checker for the non-volatile access control block.
`include "nv_access_regs.svh"
`default_nettype none
module nv_access_monitor #(
    parameter int unsigned WRITE_CYCLES = 8
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        warm_reset_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        irq_o,
    input wire logic        target_flash_o,
    input wire logic        target_eeprom_o,
    input wire logic        target_config_o,
    input wire logic        nv_write_o,
    input wire logic        nv_erase_o,
    input wire logic        nv_read_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ****
    // Helper logic
    // ****
    logic        ctl_wr;
    logic        busy;
    logic        gate_q;
    logic        next_gate_q;
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;
    // Control register writes and operation activity.
    assign ctl_wr = wr_i && (addr_i == `MAC_ADDR);
    assign busy = nv_write_o || nv_erase_o;
    // Counts how long the running operation has lasted, and keeps the
    // gate bit that software wrote last.
    always_comb begin
        next_busy_cnt = busy ? busy_cnt + 16'h0001 : 16'h0000;
        next_gate_q   = ctl_wr ? wdata_i[`MAC_WEN_BIT] : gate_q;
    end
    // Registers the operation length and the written gate bit.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt <= 16'h0000;
            gate_q   <= 1'b0;
        end else begin
            busy_cnt <= next_busy_cnt;
            gate_q   <= next_gate_q;
        end
    end
    // ****
    // Assertions
    // ****
    a_config_route: assert property (
        target_config_o |-> !target_flash_o && !target_eeprom_o)
        else $error("Config access still routes to memory.");
    a_erase_flash: assert property (
        nv_erase_o |-> target_flash_o && !nv_write_o)
        else $error("Erase runs outside flash.");
    a_program_only: assert property (
        nv_write_o |-> !nv_erase_o)
        else $error("Program and erase overlap.");
    a_op_length: assert property (
        busy_cnt <= 16'(WRITE_CYCLES + 1))
        else $error("Operation never completes.");
    a_start_cause: assert property (
        $rose(busy) |-> $past(ctl_wr && wdata_i[`MAC_WSTART_BIT]
            && gate_q))
        else $error("Operation started without a gated start write.");
    a_read_pulse: assert property (
        nv_read_o |=> !nv_read_o)
        else $error("Read start not cleared.");
    a_read_cause: assert property (
        nv_read_o |-> $past(ctl_wr && wdata_i[`MAC_RSTART_BIT]
            && !wdata_i[`MAC_MEM_SEL_BIT]))
        else $error("Read started without an eeprom read start.");
    a_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("Read data outside its slot.");
    a_warm_abort: assert property (
        $rose(warm_reset_i) |-> ##[1:5] !busy)
        else $error("Warm reset left the operation running.");
endmodule
bind nv_memory_access_control nv_access_monitor #(
    .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .clk_i(clk_i), .resetn_i(resetn_i), .warm_reset_i(warm_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .target_flash_o(target_flash_o),
    .target_eeprom_o(target_eeprom_o), .target_config_o(target_config_o),
    .nv_write_o(nv_write_o), .nv_erase_o(nv_erase_o),
    .nv_read_o(nv_read_o));
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench for the non-volatile access control block.
`include "nv_access_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        warm_reset_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_d = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o, r;
    logic        irq_o, flash_o, eeprom_o, config_o, wr_o, er_o, rd_o;
    logic        saw_wr = 1'b0, saw_er = 1'b0, saw_rd = 1'b0;
    logic [7:0]  exp_q[$];
    integer      seed = 26073;
    int          error_cnt = 0, checks = 0, cyc = 0, i;
    nv_memory_access_control #(.WRITE_CYCLES(20)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .warm_reset_i(warm_reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .target_flash_o(flash_o),
        .target_eeprom_o(eeprom_o), .target_config_o(config_o),
        .nv_write_o(wr_o), .nv_erase_o(er_o), .nv_read_o(rd_o));
    // Makes the 10 MHz clock.
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic clr;
        saw_wr = 1'b0;
        saw_er = 1'b0;
        saw_rd = 1'b0;
    endtask
    // Waits for a started operation to finish, bounded.
    task automatic wait_op;
        repeat (3) @(posedge clk_i);
        for (i = 0; i < 40 && (wr_o || er_o); i++) @(posedge clk_i);
    endtask
    // Compares read data, notes operation pulses and guards against hangs.
    always @(posedge clk_i) begin
        if (rd_d) chk(rdata_o, exp_q.pop_front());
        rd_d <= rd_i;
        if (wr_o) saw_wr <= 1'b1;
        if (er_o) saw_er <= 1'b1;
        if (rd_o) saw_rd <= 1'b1;
        cyc++;
        if (cyc > 4000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(`MAC_ADDR, 8'h00);
        rd(12'h0123, 8'h00);
        wr(`MAC_ADDR, 8'h02);
        rd(`MAC_ADDR, 8'h00);
        // Program a random byte at a random address of the data space.
        r = 8'($random(seed));
        wr(`NV_ADDRL_ADDR, 8'($random(seed)));
        wr(`NV_DATA_ADDR, r);
        wr(`MAC_ADDR, 8'h04);
        wr(`MAC_ADDR, 8'h06);
        rd(`MAC_ADDR, 8'h06);
        wr(`MAC_ADDR, 8'h04);
        rd(`MAC_ADDR, 8'h06);
        wait_op();
        chk({6'h00, saw_er, saw_wr}, 8'h01);
        // Overwrite the data register, then fetch the stored byte back.
        wr(`NV_DATA_ADDR, ~r);
        rd(`NV_DATA_ADDR, ~r);
        wr(`MAC_ADDR, 8'h05);
        rd(`NV_DATA_ADDR, r);
        rd(`MAC_ADDR, 8'h04);
        rd(`IRQ_STATUS_ADDR, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        wr(`IRQ_MASK_ADDR, 8'h03);
        settle();
        chk({7'h00, irq_o}, 8'h01);
        wr(`IRQ_STATUS_ADDR, 8'h01);
        settle();
        chk({7'h00, irq_o}, 8'h00);
        clr();
        wr(`MAC_ADDR, 8'h94);
        wr(`MAC_ADDR, 8'h96);
        wait_op();
        chk({6'h00, saw_er, saw_wr}, 8'h02);
        rd(`MAC_ADDR, 8'h84);
        wr(`IRQ_STATUS_ADDR, 8'h03);
        // Dropping the gate in mid-write must cut the write short.
        wr(`MAC_ADDR, 8'h04);
        wr(`MAC_ADDR, 8'h06);
        wr(`MAC_ADDR, 8'h00);
        settle();
        chk({7'h00, wr_o}, 8'h00);
        rd(`MAC_ADDR, 8'h08);
        rd(`IRQ_STATUS_ADDR, 8'h02);
        wr(`IRQ_STATUS_ADDR, 8'h03);
        // A warm reset in mid-write must abort it and flag the error.
        wr(`NV_DATA_ADDR, 8'h5a);
        wr(`MAC_ADDR, 8'h04);
        wr(`MAC_ADDR, 8'h06);
        repeat (3) @(posedge clk_i);
        warm_reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        warm_reset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({7'h00, wr_o}, 8'h00);
        rd(`MAC_ADDR, 8'h08);
        rd(`IRQ_STATUS_ADDR, 8'h02);
        rd(`NV_DATA_ADDR, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        wr(`IRQ_STATUS_ADDR, 8'h03);
        for (i = 0; i < 3; i++) begin
            r = (i == 0) ? 8'h40 : (i == 1) ? 8'h80 : 8'h00;
            wr(`MAC_ADDR, r);
            settle();
            chk({5'h00, config_o, flash_o, eeprom_o},
                {5'h00, r[6], r[7] & ~r[6], ~r[7] & ~r[6]});
        end
        for (i = 0; i < 3; i++) begin
            r = (i == 0) ? 8'h01 : (i == 1) ? 8'h81 : 8'h41;
            clr();
            wr(`MAC_ADDR, r);
            settle();
            chk({7'h00, saw_rd}, {7'h00, i == 0});
        end
        rd(`MAC_ADDR, 8'h40);
        print_verdict();
    end
endmodule
`default_nettype wire
